// file: ube_regs.vh
// Constants of the USB bus event and interrupt enable block.
// Assumes inclusion by the block's single design file only.
`ifndef UBE_REGS_VH
`define UBE_REGS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define UBE_ADDR_W 8
`define UBE_OFS_CSR 8'h00
`define UBE_OFS_STAT 8'h04
`define UBE_OFS_MASK 8'h08

// ----------------------------------------------------------------
// Control/status register layout
// ----------------------------------------------------------------
`define UBE_EN_MSB 31
`define UBE_EN_LSB 24
`define UBE_FLAG_MSB 23
`define UBE_FLAG_LSB 16
`define UBE_EP_MSB 7
`define UBE_EP_LSB 1

// Event index inside the enable and flag bytes
`define UBE_EV_SUPPLY 3'h7
`define UBE_EV_SESS 3'h6
`define UBE_EV_DETACH 3'h5
`define UBE_EV_ATTACH 3'h4
`define UBE_EV_FRAME 3'h3
`define UBE_EV_RSTBAB 3'h2
`define UBE_EV_WAKE 3'h1
`define UBE_EV_SLEEP 3'h0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UBE_EN_RST 8'h06
`define UBE_FLAG_RST 8'h00
`define UBE_EP_RST 7'h7f
`define UBE_STAT_RST 16'h0000
`define UBE_MASK_RST 16'h0000

// Status and mask: bits 7..0 bus events, 15..9 endpoint 7..1 receive
`define UBE_STAT_USED 16'hfeff

// AXI responses
`define UBE_RESP_OKAY 2'h0
`define UBE_RESP_SLVERR 2'h2

`endif

// file: ube_bus_events.v
// Bus event flags, interrupt enables and endpoint receive enables of a
// dual-role USB controller, reached over AXI4-Lite.
// Assumes event pulses from the USB core on aclk; the supply-valid
// comparator output is asynchronous and is synchronised here.
//
// Overview of operation
// - Supply falling below valid during a session sets the supply fault flag.
// - Detected session request signaling sets the session request flag.
// - In host role, peripheral removal sets the detach flag.
// - In peripheral role, session end sets the same detach flag.
// - In host role, peripheral attachment sets the attach flag.
// - Supply fault interrupt raised only while its enable is one.
// - Session request interrupt raised only while its enable is one.
// - Detach or session-end interrupt raised only while its enable is one.
// - Attach interrupt raised only while its enable is one.
// - Frame start interrupt raised only while its enable is one.
// - One enable gates reset (peripheral) or babble (host); resets to one.
// - Wakeup interrupt gated by its enable, which resets to one.
// - Sleep interrupt gated by its enable, which resets to zero.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`include "ube_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module ube_bus_events (
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    output wire [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    // USB core side
    input wire host_role,
    input wire session_active,
    input wire supply_valid_pin,
    input wire session_req_det,
    input wire detach_det,
    input wire session_end_det,
    input wire attach_det,
    input wire frame_start_det,
    input wire bus_reset_det,
    input wire babble_det,
    input wire wakeup_det,
    input wire sleep_det,
    input wire [7:1] ep_receive_det,
    // Interrupt outputs
    output wire usb_irq,
    output wire irq
);

    // ----------------------------------------------------------------
    // Supply valid synchroniser
    // ----------------------------------------------------------------
    reg supply_s1_q;
    reg supply_s2_q;
    reg supply_prev_q;
    wire supply_fall;

    always @(posedge aclk) begin
        if (!aresetn) begin
            supply_s1_q <= 1'b1;
            supply_s2_q <= 1'b1;
            supply_prev_q <= 1'b1;
        end else begin
            supply_s1_q <= supply_valid_pin;
            supply_s2_q <= supply_s1_q;
            supply_prev_q <= supply_s2_q;
        end
    end

    // Only the falling edge counts; a supply that stays low is one fault
    assign supply_fall = supply_prev_q & ~supply_s2_q;

    // ----------------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------------
    reg [7:0] evt;

    always @* begin
        evt = 8'h00;
        evt[`UBE_EV_SUPPLY] = supply_fall & session_active;
        evt[`UBE_EV_SESS] = session_req_det;
        evt[`UBE_EV_DETACH] = host_role ? detach_det : session_end_det;
        evt[`UBE_EV_ATTACH] = host_role & attach_det;
        evt[`UBE_EV_FRAME] = frame_start_det;
        evt[`UBE_EV_RSTBAB] = host_role ? babble_det : bus_reset_det;
        evt[`UBE_EV_WAKE] = wakeup_det;
        evt[`UBE_EV_SLEEP] = sleep_det;
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------
    reg aw_full_q;
    reg w_full_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    wire wr_fire;
    wire wr_csr;
    wire wr_stat;
    wire wr_mask;
    wire wr_hit;

    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready = ~w_full_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Both halves held and no response still owed
    assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
    assign wr_csr = wr_fire & (awaddr_q == `UBE_OFS_CSR);
    assign wr_stat = wr_fire & (awaddr_q == `UBE_OFS_STAT);
    assign wr_mask = wr_fire & (awaddr_q == `UBE_OFS_MASK);
    // Unmapped writes are dropped but still answered, so no master hangs
    assign wr_hit = wr_csr | wr_stat | wr_mask;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `UBE_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_full_q) begin
                aw_full_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_full_q) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `UBE_RESP_OKAY : `UBE_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;
    reg [31:0] rd_mux;
    reg rd_hit;
    wire rd_take;
    wire rd_csr;
    wire [7:0] araddr_w;

    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign rd_take = s_axi_arvalid & ~rvalid_q;
    assign araddr_w = {s_axi_araddr[7:2], 2'b00};
    assign rd_csr = rd_take & (araddr_w == `UBE_OFS_CSR);

    // ----------------------------------------------------------------
    // Control/status register
    // ----------------------------------------------------------------
    reg [7:0] en_q;
    reg [7:0] en_d;
    reg [7:0] flag_q;
    reg [7:0] flag_d;
    reg [7:1] ep_en_q;
    reg [7:1] ep_en_d;

    always @* begin
        en_d = en_q;
        ep_en_d = ep_en_q;
        // enables written by software, byte 3
        if (wr_csr && wstrb_q[3]) begin
            en_d = wdata_q[`UBE_EN_MSB:`UBE_EN_LSB];
        end
        if (wr_csr && wstrb_q[0]) begin
            ep_en_d = wdata_q[`UBE_EP_MSB:`UBE_EP_LSB];
        end
        // no write path; read clears, new event wins
        flag_d = (rd_csr ? 8'h00 : flag_q) | evt;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            // reset/babble and wakeup enables start set
            en_q <= `UBE_EN_RST;
            flag_q <= `UBE_FLAG_RST;
            ep_en_q <= `UBE_EP_RST;
        end else begin
            en_q <= en_d;
            flag_q <= flag_d;
            ep_en_q <= ep_en_d;
        end
    end

    // ----------------------------------------------------------------
    // Sticky interrupt status and mask
    // ----------------------------------------------------------------
    reg [15:0] stat_q;
    reg [15:0] stat_d;
    reg [15:0] mask_q;
    reg [15:0] mask_d;
    reg [15:0] stat_set;
    reg [15:0] stat_clr;

    always @* begin
        // each event gated by its enable
        stat_set = {ep_receive_det & ep_en_q, 1'b0, evt & en_q};
        stat_clr = 16'h0000;
        if (wr_stat && wstrb_q[0]) begin
            stat_clr[7:0] = wdata_q[7:0];
        end
        if (wr_stat && wstrb_q[1]) begin
            stat_clr[15:8] = wdata_q[15:8];
        end
        // Set beats write-one-to-clear in the same cycle
        stat_d = ((stat_q & ~stat_clr) | stat_set) & `UBE_STAT_USED;
        mask_d = mask_q;
        if (wr_mask && wstrb_q[0]) begin
            mask_d[7:0] = wdata_q[7:0];
        end
        if (wr_mask && wstrb_q[1]) begin
            mask_d[15:8] = wdata_q[15:8];
        end
        mask_d = mask_d & `UBE_STAT_USED;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= `UBE_STAT_RST;
            mask_q <= `UBE_MASK_RST;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (araddr_w)
            `UBE_OFS_CSR: begin
                rd_mux = {en_q, flag_q, 8'h00, ep_en_q, 1'b0};
            end
            `UBE_OFS_STAT: begin
                rd_mux = {16'h0000, stat_q};
            end
            `UBE_OFS_MASK: begin
                rd_mux = {16'h0000, mask_q};
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `UBE_RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? `UBE_RESP_OKAY : `UBE_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt outputs
    // ----------------------------------------------------------------
    wire [7:0] cause_w;

    assign cause_w[`UBE_EV_SUPPLY] = flag_q[`UBE_EV_SUPPLY] & en_q[`UBE_EV_SUPPLY];
    assign cause_w[`UBE_EV_SESS] = flag_q[`UBE_EV_SESS] & en_q[`UBE_EV_SESS];
    assign cause_w[`UBE_EV_DETACH] = flag_q[`UBE_EV_DETACH] & en_q[`UBE_EV_DETACH];
    assign cause_w[`UBE_EV_ATTACH] = flag_q[`UBE_EV_ATTACH] & en_q[`UBE_EV_ATTACH];
    assign cause_w[`UBE_EV_FRAME] = flag_q[`UBE_EV_FRAME] & en_q[`UBE_EV_FRAME];
    assign cause_w[`UBE_EV_RSTBAB] = flag_q[`UBE_EV_RSTBAB] & en_q[`UBE_EV_RSTBAB];
    assign cause_w[`UBE_EV_WAKE] = flag_q[`UBE_EV_WAKE] & en_q[`UBE_EV_WAKE];
    assign cause_w[`UBE_EV_SLEEP] = flag_q[`UBE_EV_SLEEP] & en_q[`UBE_EV_SLEEP];
    assign usb_irq = |cause_w;
    // Sticky path has its own mask, but its bus event status bits set only where the flag enables are one
    assign irq = |(stat_q & mask_q);

endmodule // ube_bus_events

`default_nettype wire

// file: ube_bus_events_sva.sv
// Checker of the bus event block, watching its top ports only.
// Assumes one clock, aresetn synchronous and active low.
`timescale 1ns/1ps
`default_nettype none
module ube_bus_events_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic host_role,
    input wire logic supply_valid_pin,
    input wire logic session_req_det,
    input wire logic detach_det,
    input wire logic session_end_det,
    input wire logic attach_det,
    input wire logic frame_start_det,
    input wire logic bus_reset_det,
    input wire logic babble_det,
    input wire logic wakeup_det,
    input wire logic sleep_det,
    input wire logic usb_irq,
    input wire logic irq
);
    // ------------------------------------------------------------
    // Shadow of flags 22..16
    // ------------------------------------------------------------
    logic [6:0] ev_w;
    logic [6:0] seen_q;
    logic [6:0] snap_q;
    logic csr_ar_w;
    assign ev_w = {session_req_det, host_role ? detach_det : session_end_det,
        host_role & attach_det, frame_start_det, host_role ? babble_det : bus_reset_det,
        wakeup_det, sleep_det};
    assign csr_ar_w = s_axi_arvalid & s_axi_arready & (s_axi_araddr[7:2] == 6'h00);
    // Set wins over the clear on read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen_q <= 7'h00;
            snap_q <= 7'h00;
        end else begin
            seen_q <= (csr_ar_w ? 7'h00 : seen_q) | ev_w;
            if (csr_ar_w) begin
                snap_q <= seen_q;
            end
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence csr_rd_s;
        csr_ar_w ##1 s_axi_rvalid;
    endsequence
    reset_clear_a: assert property ($rose(aresetn) |-> !usb_irq && !irq)
        else $error("interrupt outputs set after reset");
    sess_flag_a: assert property (csr_rd_s |-> s_axi_rdata[22] == snap_q[6])
        else $error("session request flag wrong");
    detach_flag_a: assert property (csr_rd_s |-> s_axi_rdata[21] == snap_q[5])
        else $error("detach flag wrong");
    attach_flag_a: assert property (csr_rd_s |-> s_axi_rdata[20] == snap_q[4])
        else $error("attach flag wrong");
    frame_flag_a: assert property (csr_rd_s |-> s_axi_rdata[19] == snap_q[3])
        else $error("frame start flag wrong");
    rstbab_flag_a: assert property (csr_rd_s |-> s_axi_rdata[18] == snap_q[2])
        else $error("reset or babble flag wrong");
    wake_sleep_a: assert property (csr_rd_s |-> s_axi_rdata[17:16] == snap_q[1:0])
        else $error("wakeup or sleep flag wrong");
    zero_bits_a: assert property (csr_rd_s |-> s_axi_rdata[15:8] == 8'h00 && !s_axi_rdata[0])
        else $error("unused bits not zero");
    irq_cause_a: assert property ($rose(usb_irq) |-> $rose(s_axi_bvalid) || $past(|ev_w)
        || !$past(supply_valid_pin, 3) || !$past(supply_valid_pin, 4))
        else $error("usb_irq rose without cause");
endmodule // ube_bus_events_sva
bind ube_bus_events ube_bus_events_sva chk (.*);
`default_nettype wire

// file: ube_usb_model.sv
// Far-side model: the USB core that reports bus events to the block.
// Assumes commands from the bench on aclk, one event per command.
`timescale 1ns/1ps
`default_nettype none
module ube_usb_model (
    input wire logic aclk,
    input wire logic ev_go,
    input wire logic [3:0] ev_sel,
    output wire logic [15:0] ev_q
);
    logic [15:0] pulse_q = 16'h0000;
    // One-cycle pulses; a held level would count as many events
    always @(posedge aclk) begin
        pulse_q <= ev_go ? (16'h0001 << ev_sel) : 16'h0000;
    end
    assign ev_q = pulse_q;
endmodule // ube_usb_model
`default_nettype wire

// file: ube_bus_events_tb_top.sv
// Testbench of the bus event block: AXI4-Lite tasks and event pulses.
// Assumes the checker is bound in and the far-side model is present.
`timescale 1ns/1ps
`default_nettype none
module ube_bus_events_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic host_role = 1'b0, session_active = 1'b0, supply_valid_pin = 1'b1;
    logic ev_go = 1'b0;
    logic [3:0] ev_sel = 4'h0;
    wire logic [15:0] ev_q;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic usb_irq, irq;
    int mismatches = 0;
    int check_count = 0;
    logic [31:0] rd_d;
    logic [1:0] rsp;
    int fb[9] = '{22, 21, 21, 20, 19, 18, 18, 17, 16};
    logic [8:0] hr = 9'h04a;
    ube_usb_model far (.aclk(aclk), .ev_go(ev_go), .ev_sel(ev_sel), .ev_q(ev_q));
    ube_bus_events uut (.*, .session_req_det(ev_q[0]), .detach_det(ev_q[1]),
        .session_end_det(ev_q[2]), .attach_det(ev_q[3]), .frame_start_det(ev_q[4]),
        .bus_reset_det(ev_q[5]), .babble_det(ev_q[6]), .wakeup_det(ev_q[7]),
        .sleep_det(ev_q[8]), .ep_receive_det(ev_q[15:9]));
    initial forever #10 aclk = ~aclk;
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_bready <= 1'b1;
        s_axi_wvalid <= 1'b1; s_axi_wdata <= d; s_axi_wstrb <= s;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rd_d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Flag is visible on the same edge that samples the model's pulse
    task ev(input int s, input logic h);
        @(posedge aclk);
        ev_sel <= s[3:0]; ev_go <= 1'b1; host_role <= h;
        @(posedge aclk);
        ev_go <= 1'b0;
        @(posedge aclk);
        #1;
    endtask
    task ck(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done;
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00); ck(rd_d, 32'h060000fe);
        rd(8'h40); ck({rd_d[31:2], rsp}, 32'h2);
        wr(8'h40, 32'hffffffff, 4'hf); ck({30'h0, rsp}, 32'h2);
        wr(8'h00, 32'h00ff0000, 4'hf); rd(8'h00); ck(rd_d, 32'h0);
        for (int i = 0; i < 9; i++) begin
            ev(i, hr[i]); ck({31'h0, usb_irq}, 32'h0);
            rd(8'h00); ck(rd_d, 32'h1 << fb[i]);
        end
        ev(3, 1'b0); rd(8'h00); ck(rd_d, 32'h0);
        ev(1, 1'b0); ev(2, 1'b1); ev(5, 1'b1); ev(6, 1'b0);
        rd(8'h00); ck(rd_d, 32'h0);
        wr(8'h00, 32'hff0000fe, 4'hf);
        for (int i = 0; i < 9; i++) begin
            ev(i, hr[i]); ck({31'h0, usb_irq}, 32'h1);
            rd(8'h00); ck(rd_d, 32'hff0000fe | (32'h1 << fb[i]));
            ck({31'h0, usb_irq}, 32'h0);
        end
        @(posedge aclk);
        supply_valid_pin <= 1'b0;
        repeat (5) @(posedge aclk);
        supply_valid_pin <= 1'b1;
        repeat (5) @(posedge aclk);
        #1;
        ck({31'h0, usb_irq}, 32'h0);
        @(posedge aclk);
        session_active <= 1'b1; supply_valid_pin <= 1'b0;
        repeat (5) @(posedge aclk);
        #1;
        ck({31'h0, usb_irq}, 32'h1);
        rd(8'h00); ck(rd_d, 32'hff8000fe);
        ck({31'h0, irq}, 32'h0);
        @(posedge aclk);
        supply_valid_pin <= 1'b1;
        wr(8'h04, 32'h0000ffff, 4'hf); wr(8'h08, 32'h00000200, 4'hf); ck({30'h0, rsp}, 32'h0);
        ev(9, 1'b0); ck({31'h0, irq}, 32'h1);
        rd(8'h04); ck(rd_d, 32'h00000200); ck({30'h0, rsp}, 32'h0);
        wr(8'h04, 32'h00000200, 4'h2); rd(8'h04); ck(rd_d, 32'h0);
        ck({31'h0, irq}, 32'h0);
        wr(8'h00, 32'hff000000, 4'h1); ev(9, 1'b0);
        rd(8'h04); ck(rd_d, 32'h0);
        rd(8'h00); ck(rd_d, 32'hff000000);
        test_done;
    end
endmodule // ube_bus_events_tb_top
`default_nettype wire
